// ==== logic/rhw_hour_scale.sv ====
// Hour-scale select and day-of-week registers with hour digit conversion.
// Assumes an APB master on i_clk and a day rollover pulse on the same clock.
//
// Summary of operation
// - A read/write bit 0 selects the 24-hour scale when 1 and the 12-hour scale when 0, and resets to 1.
// - The chosen scale applies to the hour digits of both the loaded time and the alarm value.
// - In 12-hour scale midnight reads 12 and morning hours one to eleven read 01 to 11.
// - In 12-hour scale noon reads 32 and afternoon hours one to eleven read 21 to 31.
// - The weekday is a three-bit read/write field from 0 for Sunday up to 6 for Saturday.
// - The weekday resets to 6 and all bits above it read as zero.
// - Hour digits are handled as BCD and written values are never checked.

`timescale 1ns/1ps
`default_nettype none

module rhw_hour_scale
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Hour digits written by software in the active scale
    input  wire rhw_pkg::rhw_hour_t i_load_hour,
    input  wire rhw_pkg::rhw_hour_t i_alarm_hour,
    // Counter hour in 24-hour code
    input  wire rhw_pkg::rhw_hour_t i_count_hour,
    // Day rollover pulse from the calendar counter
    input  wire logic              i_day_rollover,
    // Converted hours
    output rhw_pkg::rhw_hour_t     o_load_hour24,
    output rhw_pkg::rhw_hour_t     o_alarm_hour24,
    output rhw_pkg::rhw_hour_t     o_count_hour_scaled,
    // Register state
    output logic                   o_hour_scale_bit,
    output logic [2:0]             o_day_of_week
);
    import rhw_pkg::*;

    // ************************************************
    // Elaboration checks
    // ************************************************
    generate
        if (ADDR_W < 8)
        begin : g_addr_chk
            $error("ADDR_W must be at least 8");
        end
        // The weekday port and field must agree, or a write would be cut or padded
        if (RHW_DOW_W != $bits(o_day_of_week))
        begin : g_dow_chk
            $error("Weekday field width does not match its port");
        end
        // Each register takes one aligned word
        if ((RHW_OFS_SCALE[1:0] != 2'b00) || (RHW_OFS_WEEKDAY[1:0] != 2'b00))
        begin : g_align_chk
            $error("Register offsets must be word aligned");
        end
    endgenerate

    // ************************************************
    // Conversion functions
    // ************************************************
    // 12-hour code to 24-hour code; odd codes go unchecked and pass through only when tens is below 2
    function automatic rhw_hour_t to_24(input rhw_hour_t h);
        rhw_hour_t r;
        logic [3:0] o;
        logic [1:0] t;
        r = h;
        o = 4'h0;
        t = 2'h0;
        if (h.tens >= RHW_PM_TENS)
        begin
            if (h == RHW_H_PM_NOON)
            begin
                r = RHW_H_NOON;
            end
            else
            begin
                // Strip PM offset then add twelve in BCD
                t = h.tens - RHW_PM_TENS + RHW_TENS_ONE;
                o = h.ones + RHW_ONES_TWO;
                if (o > RHW_ONES_NINE)
                begin
                    o = o - RHW_ONES_TEN;
                    t = t + RHW_TENS_ONE;
                end
                r.tens = t;
                r.ones = o;
            end
        end
        else if (h == RHW_H_NOON)
        begin
            r = RHW_H_ZERO;
        end
        return r;
    endfunction

    // 24-hour code to 12-hour code
    function automatic rhw_hour_t to_12(input rhw_hour_t h);
        rhw_hour_t r;
        logic [3:0] o;
        logic [1:0] t;
        r = h;
        o = 4'h0;
        t = 2'h0;
        if (h == RHW_H_ZERO)
        begin
            r = RHW_H_NOON;
        end
        else if (h == RHW_H_NOON)
        begin
            r = RHW_H_PM_NOON;
        end
        else if (h > RHW_H_NOON)
        begin
            // Subtract twelve in BCD then add the PM tens offset
            if (h.ones < RHW_ONES_TWO)
            begin
                o = h.ones + RHW_ONES_EIGHT;
                t = h.tens - RHW_PM_TENS;
            end
            else
            begin
                o = h.ones - RHW_ONES_TWO;
                t = h.tens - RHW_TENS_ONE;
            end
            r.tens = t + RHW_PM_TENS;
            r.ones = o;
        end
        return r;
    endfunction

    // Register select; the upper address bits must be clear so aliases stay unmapped
    function automatic logic reg_hit(input logic [7:0] low, input logic [7:0] ofs, input logic upper_ok);
        return upper_ok && (low == ofs);
    endfunction

    // ************************************************
    // Registers
    // ************************************************
    logic             scale_q;
    logic [2:0]       dow_q;
    logic [2:0]       dow_d;
    logic             pready_q;
    logic             pslverr_q;
    logic [31:0]      prdata_q;
    rhw_hour_t        load24_q;
    rhw_hour_t        alarm24_q;
    rhw_hour_t        cnt12_q;

    // ************************************************
    // Bus decode
    // ************************************************
    rhw_apb_req_t     req;
    wire logic        access;
    wire logic        commit;
    wire logic        wr_commit;
    wire logic        hit_scale;
    wire logic        hit_dow;
    wire logic        mapped;
    wire logic        upper_zero;
    wire logic        wr_scale;
    wire logic        wr_dow;
    wire logic        first_cycle;
    wire logic        rd_take;
    wire logic [31:0] rd_mux;

    assign req.psel    = i_psel;
    assign req.penable = i_penable;
    assign req.pwrite  = i_pwrite;
    assign req.paddr   = i_paddr[7:0];
    assign req.pwdata  = i_pwdata;

    // One wait state: pready rises in the second access cycle
    assign access    = req.psel & req.penable;
    assign commit    = access & pready_q;
    assign wr_commit = commit & req.pwrite;
    assign upper_zero  = ((i_paddr >> $bits(req.paddr)) == '0);
    assign hit_scale   = reg_hit(req.paddr, RHW_OFS_SCALE, upper_zero);
    assign hit_dow     = reg_hit(req.paddr, RHW_OFS_WEEKDAY, upper_zero);
    assign mapped      = hit_scale | hit_dow;
    assign wr_scale    = wr_commit & hit_scale;
    assign wr_dow      = wr_commit & hit_dow;
    // Only the first access cycle answers, so pready stands for exactly one cycle
    assign first_cycle = access & ~pready_q;
    assign rd_take     = first_cycle & ~req.pwrite;

    // Reserved bits read as zero
    assign rd_mux = hit_scale ? {31'h0000_0000, scale_q} :
                    hit_dow   ? {29'h0000_0000, dow_q}   :
                                32'h0000_0000;

    // ************************************************
    // Weekday next value
    // ************************************************
    // A software write in the rollover cycle wins, as it reloads the day
    always_comb
    begin
        dow_d = dow_q;
        if (wr_dow)
        begin
            dow_d = req.pwdata[RHW_DOW_W-1:0];
        end
        else if (i_day_rollover)
        begin
            dow_d = (dow_q >= RHW_DOW_LAST) ? RHW_DOW_FIRST : dow_q + 3'h1;
        end
    end

    // ************************************************
    // Register state
    // ************************************************
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            scale_q <= RHW_RST_SCALE[RHW_SCALE_BIT];
            dow_q   <= RHW_RST_WEEKDAY[RHW_DOW_W-1:0];
        end
        else
        begin
            // Writes land at the edge that sees pready high
            if (wr_scale)
            begin
                scale_q <= req.pwdata[RHW_SCALE_BIT];
            end
            dow_q <= dow_d;
        end
    end

    // ************************************************
    // APB answer
    // ************************************************
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= first_cycle;
            // Unmapped addresses answer with an error and drop writes
            pslverr_q <= first_cycle & ~mapped;
            prdata_q  <= rd_take ? rd_mux : 32'h0000_0000;
        end
    end

    // ************************************************
    // Hour conversion
    // ************************************************
    // The scale bit is read live, so a scale write shows on the next converted value
    wire rhw_hour_t   load_sel;
    wire rhw_hour_t   alarm_sel;
    wire rhw_hour_t   cnt_sel;

    assign load_sel  = scale_q ? i_load_hour  : to_24(i_load_hour);
    assign alarm_sel = scale_q ? i_alarm_hour : to_24(i_alarm_hour);
    assign cnt_sel   = scale_q ? i_count_hour : to_12(i_count_hour);

    // Registered so every output comes from a flop; one cycle of lag
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            load24_q  <= RHW_H_ZERO;
            alarm24_q <= RHW_H_ZERO;
            cnt12_q   <= RHW_H_ZERO;
        end
        else
        begin
            load24_q  <= load_sel;
            alarm24_q <= alarm_sel;
            cnt12_q   <= cnt_sel;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign o_prdata            = prdata_q;
    assign o_pready            = pready_q;
    assign o_pslverr           = pslverr_q;
    assign o_load_hour24       = load24_q;
    assign o_alarm_hour24      = alarm24_q;
    assign o_count_hour_scaled = cnt12_q;
    assign o_hour_scale_bit    = scale_q;
    assign o_day_of_week       = dow_q;

endmodule

`default_nettype wire

// ==== logic/rhw_pkg.sv ====
// Package for the hour-scale and weekday block of the clock.
// Assumes an APB slave with 32-bit data and byte addresses.

package rhw_pkg;

    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0]  RHW_OFS_SCALE   = 8'h14;
    localparam logic [7:0]  RHW_OFS_WEEKDAY = 8'h18;
    localparam logic [31:0] RHW_RST_SCALE   = 32'h0000_0001;
    localparam logic [31:0] RHW_RST_WEEKDAY = 32'h0000_0006;

    // ************************************************
    // Field layout
    // ************************************************
    localparam int          RHW_SCALE_BIT   = 0;
    localparam int          RHW_DOW_W       = 3;
    localparam logic [2:0]  RHW_DOW_FIRST   = 3'h0;
    localparam logic [2:0]  RHW_DOW_LAST    = 3'h6;
    localparam logic        RHW_SCALE_24    = 1'b1;

    // ************************************************
    // Hour digit codes
    // ************************************************
    localparam logic [1:0]  RHW_PM_TENS     = 2'h2;
    localparam logic [5:0]  RHW_H_ZERO      = 6'h00;
    localparam logic [5:0]  RHW_H_NOON      = 6'h12;
    localparam logic [5:0]  RHW_H_PM_NOON   = 6'h32;
    localparam logic [3:0]  RHW_ONES_TWO    = 4'h2;
    localparam logic [3:0]  RHW_ONES_EIGHT  = 4'h8;
    localparam logic [3:0]  RHW_ONES_NINE   = 4'h9;
    localparam logic [3:0]  RHW_ONES_TEN    = 4'ha;
    localparam logic [1:0]  RHW_TENS_ONE    = 2'h1;

    // Hour digits as they sit in bits [21:16] of the time values
    typedef struct packed {
        logic [1:0] tens;
        logic [3:0] ones;
    } rhw_hour_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } rhw_apb_req_t;

endpackage

// ==== dv/rhw_hour_scale_sva.sv ====
// Port assertions for the hour-scale and weekday block.
// Assumes APB transfers and a one-cycle rollover pulse on i_clk.
`timescale 1ns/1ps
`default_nettype none
module rhw_hour_scale_sva
    import rhw_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    // APB
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic              o_pready,
    // Hours and weekday
    input wire rhw_hour_t         i_load_hour,
    input wire rhw_hour_t         i_alarm_hour,
    input wire rhw_hour_t         i_count_hour,
    input wire logic              i_day_rollover,
    input wire rhw_hour_t         o_load_hour24,
    input wire rhw_hour_t         o_alarm_hour24,
    input wire rhw_hour_t         o_count_hour_scaled,
    input wire logic              o_hour_scale_bit,
    input wire logic [2:0]        o_day_of_week
);
    // ****************************************
    // Taken writes
    // ****************************************
    logic wr_scale;
    logic wr_dow;
    assign wr_scale = i_psel && i_penable && i_pwrite && o_pready && i_paddr == ADDR_W'(RHW_OFS_SCALE);
    assign wr_dow   = i_psel && i_penable && i_pwrite && o_pready && i_paddr == ADDR_W'(RHW_OFS_WEEKDAY);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    chk_scale_write: assert property (wr_scale |=> o_hour_scale_bit == $past(i_pwdata[0]))
        else $error("scale bit not written");
    chk_scale_hold: assert property (!wr_scale |=> $stable(o_hour_scale_bit))
        else $error("scale bit changed");
    chk_dow_write: assert property (wr_dow |=> o_day_of_week == $past(i_pwdata[2:0]))
        else $error("weekday not written");
    chk_dow_hold: assert property (!wr_dow && !i_day_rollover |=> $stable(o_day_of_week))
        else $error("weekday changed");
    chk_dow_roll: assert property (i_day_rollover && !wr_dow |=>
        o_day_of_week == ($past(o_day_of_week) >= 3'h6 ? 3'h0 : $past(o_day_of_week) + 3'h1))
        else $error("weekday step wrong");
    // Reset still sampled low means the flops held their reset value at that edge
    chk_am_midnight: assert property (i_reset_n && !o_hour_scale_bit && i_load_hour == 6'h12 |=> o_load_hour24 == 6'h00)
        else $error("midnight code wrong");
    chk_pm_noon: assert property (i_reset_n && !o_hour_scale_bit && i_alarm_hour == 6'h32 |=> o_alarm_hour24 == 6'h12)
        else $error("noon code wrong");
    chk_pass_24: assert property (i_reset_n && o_hour_scale_bit |=> o_count_hour_scaled == $past(i_count_hour))
        else $error("24-hour passthrough wrong");
endmodule
bind rhw_hour_scale rhw_hour_scale_sva #(.ADDR_W(ADDR_W)) i_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .i_load_hour(i_load_hour), .i_alarm_hour(i_alarm_hour),
    .i_count_hour(i_count_hour), .i_day_rollover(i_day_rollover), .o_load_hour24(o_load_hour24),
    .o_alarm_hour24(o_alarm_hour24), .o_count_hour_scaled(o_count_hour_scaled),
    .o_hour_scale_bit(o_hour_scale_bit), .o_day_of_week(o_day_of_week));
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the hour-scale and weekday block.
// Assumes the APB slave answers with pready; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rhw_pkg::*;
    logic         i_clk;
    logic         i_reset_n;
    rhw_apb_req_t req;
    rhw_hour_t    ld, al, cnt, lh, ah, ch;
    logic         roll, rdy, ps, scale;
    logic [31:0]  pr;
    logic [2:0]   dow;
    int           errors;
    int           checked;
    // Rows of {24-hour code, 12-hour code}
    logic [11:0]  rows [8] = '{{6'h00, 6'h12}, {6'h01, 6'h01}, {6'h09, 6'h09}, {6'h11, 6'h11},
                               {6'h12, 6'h32}, {6'h13, 6'h21}, {6'h21, 6'h29}, {6'h23, 6'h31}};

    rhw_hour_scale i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(req.psel),
        .i_penable(req.penable), .i_pwrite(req.pwrite), .i_paddr(req.paddr), .i_pwdata(req.pwdata),
        .o_prdata(pr), .o_pready(rdy), .o_pslverr(ps), .i_load_hour(ld), .i_alarm_hour(al),
        .i_count_hour(cnt), .i_day_rollover(roll), .o_load_hour24(lh), .o_alarm_hour24(ah),
        .o_count_hour_scaled(ch), .o_hour_scale_bit(scale), .o_day_of_week(dow));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic report_and_stop;
        $display("Checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The request stands until pready is seen high; only the watchdog ends a silent wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, x, input logic xe);
        @(posedge i_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge i_clk);
        req.penable <= 1'b1;
        do
        begin
            @(negedge i_clk);
        end
        while (rdy !== 1'b1);
        if (!w)
            chk("prdata", pr, x);
        chk("pslverr", 32'(ps), 32'(xe));
        @(posedge i_clk);
        req <= '0;
        @(negedge i_clk);
        chk("pready low", 32'(rdy), 32'h0000_0000);
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    initial
    begin
        repeat (5000) @(posedge i_clk);
        errors++;
        report_and_stop();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        i_reset_n = 1'b0;
        req = '0;
        ld = '0;
        al = '0;
        cnt = '0;
        roll = 1'b0;
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        apb(1'b0, 8'h14, 32'h0, 32'h0000_0001, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h0000_0006, 1'b0);
        apb(1'b1, 8'h14, 32'hffff_fffe, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h0000_0000, 1'b0);
        foreach (rows[k])
        begin
            @(posedge i_clk);
            ld <= rows[k][5:0];
            al <= rows[k][5:0];
            cnt <= rows[k][11:6];
            @(posedge i_clk);
            @(negedge i_clk);
            chk("load", 32'(lh), 32'(rows[k][11:6]));
            chk("alarm", 32'(ah), 32'(rows[k][11:6]));
            chk("count", 32'(ch), 32'(rows[k][5:0]));
        end
        apb(1'b1, 8'h18, 32'hffff_fff5, 32'h0, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h0000_0005, 1'b0);
        for (int k = 0; k < 7; k++)
        begin
            apb(1'b1, 8'h18, 32'(k), 32'h0, 1'b0);
            apb(1'b0, 8'h18, 32'h0, 32'(k), 1'b0);
        end
        apb(1'b1, 8'h10, 32'h0000_0003, 32'h0, 1'b1);
        apb(1'b0, 8'h1c, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h18, 32'h0, 32'h0000_0006, 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge i_clk);
            roll <= 1'b1;
            @(posedge i_clk);
            roll <= 1'b0;
            @(negedge i_clk);
            chk("weekday", 32'(dow), 32'(k));
        end
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("scale rst", 32'(scale), 32'h0000_0001);
        chk("weekday rst", 32'(dow), 32'h0000_0006);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        ld <= 6'h2f;
        al <= 6'h2f;
        cnt <= 6'h2f;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("load24", 32'(lh), 32'h0000_002f);
        chk("alarm24", 32'(ah), 32'h0000_002f);
        chk("count24", 32'(ch), 32'h0000_002f);
        report_and_stop();
    end
endmodule
`default_nettype wire
